// File: hw/jtag_flash_data_access.sv
// test access port with indirect flash registers and debug halt control
//
// Overview of operation
// - ten-bit data register, byte in bits nine-two
// - bit one flags failed previous flash operation
// - bit zero reads one while request processing
// - no new operation starts while busy
// - watchdog disabled while core halted
// - other peripherals keep running under debug
// - all access through four-pin test port
// - adapter inspects memory, halts, steps, resumes
// - two-bit opcode on top selects poll/read/write
// - write mode programs byte, then pointer increments
// - read mode starts flash read when idle
`timescale 1ns/1ps
`include "jtag_flash_cfg.svh"
module jtag_flash_data_access
  import jtag_flash_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_rd_en,
  output logic flash_wr_en,
  output logic flash_erase_en,
  output logic flash_scratch,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_done,
  input wire logic flash_locked,
  input wire logic bkpt_hit,
  output logic core_halt,
  output logic core_step,
  output logic watchdog_enable
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic target_e target_of(input logic [`IR_WIDTH-1:0] code);
    unique case (code)
      `IR_MODE_SEL: target_of = TGT_MODE;
      `IR_DATA_SEL: target_of = TGT_DATA;
      `IR_POINTER_SEL: target_of = TGT_POINTER;
      `IR_DEBUG_SEL: target_of = TGT_DEBUG;
      default: target_of = TGT_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // tap controller (link clock)
  // ----------------------------------------------------------------------
  tap_state_e tap, next_tap;

  // only the four test pins reach this logic; no other channel exists
  always_comb
  begin
    next_tap = tap;
    unique case (tap)
      TAP_RESET: next_tap = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_tap = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_tap = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_tap = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_tap = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_tap = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_tap = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  always_ff @(posedge tck or negedge reset_n)
  begin
    if (!reset_n)
      tap <= TAP_RESET;
    else
      tap <= next_tap;
  end

  // ----------------------------------------------------------------------
  // instruction and data shift paths (link clock)
  // ----------------------------------------------------------------------
  logic [`IR_WIDTH-1:0] ir, next_ir, ir_sh, next_ir_sh;
  logic [`DR_WIDTH-1:0] dr, next_dr;
  logic req_tog, next_req_tog;
  logic op_write, next_op_write;
  target_e op_target, next_op_target;
  logic [17:0] op_wdata, next_op_wdata;
  logic [1:0] ack_sync;
  logic pending;
  logic [17:0] rdata_q;
  target_e ir_target;
  logic ack_tog, next_ack_tog;
  logic halted, next_halted;

  // busy covers the whole round trip of a request across both clocks
  assign pending = req_tog ^ ack_sync[1];
  assign ir_target = target_of(ir);

  always_comb
  begin
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_dr = dr;
    next_req_tog = req_tog;
    next_op_write = op_write;
    next_op_target = op_target;
    next_op_wdata = op_wdata;
    unique case (tap)
      TAP_RESET:
        next_ir = `IR_BYPASS_SEL;
      TAP_CAP_IR:
        next_ir_sh = `IR_CAPTURE_CODE;
      TAP_SHIFT_IR:
        next_ir_sh = {tdi, ir_sh[`IR_WIDTH-1:1]};
      TAP_UPD_IR:
        next_ir = ir_sh;
      TAP_CAP_DR:
        // outgoing layout: zero, right-justified read data, busy in bit 0
        next_dr = (ir_target == TGT_NONE) ? '0 :
                  {1'b0, rdata_q, pending};
      TAP_SHIFT_DR:
        if (ir_target == TGT_NONE)
          next_dr = {{(`DR_WIDTH-1){1'b0}}, tdi};
        else
          next_dr = {tdi, dr[`DR_WIDTH-1:1]};
      TAP_UPD_DR:
        // opcode 0x polls; read or write is dropped while busy
        if (ir_target != TGT_NONE && dr[`OP_ENABLE_BIT] &&
            !pending)
        begin
          next_req_tog = ~req_tog;
          next_op_write = dr[`OP_WRITE_BIT];
          next_op_target = ir_target;
          next_op_wdata = dr[`WDATA_HI:0];
        end
      default:
        next_dr = dr;
    endcase
  end

  always_ff @(posedge tck or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ir <= `IR_BYPASS_SEL;
      ir_sh <= `IR_CAPTURE_CODE;
      dr <= '0;
      req_tog <= 1'b0;
      op_write <= 1'b0;
      op_target <= TGT_NONE;
      op_wdata <= 18'h00000;
    end
    else
    begin
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      dr <= next_dr;
      req_tog <= next_req_tog;
      op_write <= next_op_write;
      op_target <= next_op_target;
      op_wdata <= next_op_wdata;
    end
  end

  // ack returns from the system clock; first stage feeds only the second
  always_ff @(posedge tck or negedge reset_n)
  begin
    if (!reset_n)
      ack_sync <= 2'b00;
    else
      ack_sync <= {ack_sync[0], ack_tog};
  end

  // ----------------------------------------------------------------------
  // test data out, launched on the falling edge
  // ----------------------------------------------------------------------
  logic next_tdo, next_tdo_oe;

  always_comb
  begin
    next_tdo = (tap == TAP_SHIFT_IR) ? ir_sh[0] : dr[0];
    next_tdo_oe = (tap == TAP_SHIFT_IR) || (tap == TAP_SHIFT_DR);
  end

  always_ff @(negedge tck or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end

  // ----------------------------------------------------------------------
  // request crossing and routing (system clock)
  // ----------------------------------------------------------------------
  // op fields stay still while pending, so they are read without sync
  logic [1:0] req_sync;
  logic req_seen;
  logic start;
  logic [17:0] next_rdata_q;
  logic dbg_cmd;
  flash_req_if req ();

  assign start = req_sync[1] ^ req_seen;
  assign dbg_cmd = start && (op_target == TGT_DEBUG);
  assign req.start = start && (op_target != TGT_DEBUG);
  assign req.is_write = op_write;
  assign req.target = op_target;
  assign req.wdata = op_wdata;

  always_comb
  begin
    next_ack_tog = ack_tog;
    next_rdata_q = rdata_q;
    if (req.done)
    begin
      next_ack_tog = ~ack_tog;
      next_rdata_q = req.rdata;
    end
    else if (dbg_cmd)
    begin
      next_ack_tog = ~ack_tog;
      next_rdata_q = {17'h00000, halted};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_sync <= 2'b00;
      req_seen <= 1'b0;
      ack_tog <= 1'b0;
      rdata_q <= 18'h00000;
    end
    else
    begin
      req_sync <= {req_sync[0], req_tog};
      req_seen <= req_sync[1];
      ack_tog <= next_ack_tog;
      rdata_q <= next_rdata_q;
    end
  end

  // memory contents are inspected and changed through this engine
  flash_engine engine (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .req(req),
    .flash_addr(flash_addr),
    .flash_wdata(flash_wdata),
    .flash_rd_en(flash_rd_en),
    .flash_wr_en(flash_wr_en),
    .flash_erase_en(flash_erase_en),
    .flash_scratch(flash_scratch),
    .flash_rdata(flash_rdata),
    .flash_done(flash_done),
    .flash_locked(flash_locked)
  );

  // ----------------------------------------------------------------------
  // halt, step and watchdog control (system clock)
  // ----------------------------------------------------------------------
  logic next_core_halt, next_core_step, next_watchdog_enable;
  logic step_now;

  assign step_now = dbg_cmd && op_write && op_wdata[`DBG_STEP_BIT] && halted;

  always_comb
  begin
    next_halted = halted;
    if (dbg_cmd && op_write && op_wdata[`DBG_RESUME_BIT])
      next_halted = 1'b0;
    if ((dbg_cmd && op_write && op_wdata[`DBG_HALT_BIT]) || bkpt_hit)
      next_halted = 1'b1;
    // a step frees the core for one cycle, then it is halted again
    next_core_step = step_now;
    next_core_halt = next_halted && !step_now;
    // only the watchdog follows the halt; nothing else is gated
    next_watchdog_enable = !next_core_halt;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      halted <= 1'b0;
      core_halt <= 1'b0;
      core_step <= 1'b0;
      watchdog_enable <= 1'b1;
    end
    else
    begin
      halted <= next_halted;
      core_halt <= next_core_halt;
      core_step <= next_core_step;
      watchdog_enable <= next_watchdog_enable;
    end
  end
endmodule // jtag_flash_data_access

// File: hw/jtag_flash_cfg.svh
// offsets, field positions, reset values and codes of the flash test port
`ifndef JTAG_FLASH_CFG_SVH
`define JTAG_FLASH_CFG_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define IR_WIDTH 4
`define IR_CAPTURE_CODE 4'h1
`define IR_MODE_SEL 4'h4
`define IR_DATA_SEL 4'h5
`define IR_POINTER_SEL 4'h6
`define IR_DEBUG_SEL 4'h7
`define IR_BYPASS_SEL 4'hF

// ----------------------------------------------------------------------
// indirect data register layout
// ----------------------------------------------------------------------
`define DR_WIDTH 20
`define OP_ENABLE_BIT 19
`define OP_WRITE_BIT 18
`define WDATA_HI 17
`define WDATA_WIDTH 18

// ----------------------------------------------------------------------
// flash_byte_port fields; byte port, pointer and mode resets
// ----------------------------------------------------------------------
`define BYTE_FIELD_HI 9
`define BYTE_FIELD_LO 2
`define FAIL_BIT 1
`define BUSY_BIT 0
`define BYTE_PORT_RESET 10'h000
`define POINTER_RESET 16'h0000
`define MODE_RESET 8'h00

// ----------------------------------------------------------------------
// flash_mode_control fields and codes
// ----------------------------------------------------------------------
`define SCRATCH_BIT 7
`define WRITE_MODE_HI 6
`define WRITE_MODE_LO 4
`define READ_MODE_HI 3
`define READ_MODE_LO 0
`define WRMD_PROGRAM 3'h1
`define WRMD_ERASE 3'h2
`define RDMD_BLOCK 4'h1
`define RDMD_SINGLE 4'h2
`define ERASE_KEY 8'hA5

// ----------------------------------------------------------------------
// debug control bits, left justified in the write data
// ----------------------------------------------------------------------
`define DBG_HALT_BIT 17
`define DBG_STEP_BIT 16
`define DBG_RESUME_BIT 15

`endif

// File: hw/jtag_flash_pkg.sv
// types shared by the flash test port modules
package jtag_flash_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_e;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_MODE, TGT_DATA, TGT_POINTER, TGT_DEBUG
  } target_e;

  typedef enum logic [1:0] {
    ENG_IDLE, ENG_READ, ENG_WRITE, ENG_ERASE
  } engine_state_e;

endpackage

// File: hw/flash_req_if.sv
// request carrier between the test port top and the flash engine
`timescale 1ns/1ps
interface flash_req_if;
  import jtag_flash_pkg::*;
  logic start;
  logic is_write;
  target_e target;
  logic [17:0] wdata;
  logic done;
  logic [17:0] rdata;
  modport host (output start, is_write, target, wdata, input done, rdata);
  modport engine (input start, is_write, target, wdata, output done, rdata);
endinterface

// File: hw/flash_engine.sv
// flash interface logic on the system clock: mode, byte port and pointer
`timescale 1ns/1ps
`include "jtag_flash_cfg.svh"
module flash_engine
  import jtag_flash_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  flash_req_if.engine req,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_rd_en,
  output logic flash_wr_en,
  output logic flash_erase_en,
  output logic flash_scratch,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_done,
  input wire logic flash_locked
);
  engine_state_e state, next_state;
  logic [7:0] mode, next_mode;
  logic [7:0] byte_field, next_byte_field;
  logic fail, next_fail;
  logic [15:0] pointer, next_pointer;
  logic unread, next_unread;
  logic [17:0] rdata, next_rdata;
  logic done, next_done;
  logic rd_en, next_rd_en;
  logic wr_en, next_wr_en;
  logic er_en, next_er_en;
  logic [15:0] addr, next_addr;
  logic [7:0] wbyte, next_wbyte;
  logic [2:0] write_mode;
  logic [3:0] read_mode;

  assign write_mode = mode[`WRITE_MODE_HI:`WRITE_MODE_LO];
  assign read_mode = mode[`READ_MODE_HI:`READ_MODE_LO];

  // ----------------------------------------------------------------------
  // request handling
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_byte_field = byte_field;
    next_fail = fail;
    next_pointer = pointer;
    next_unread = unread;
    next_rdata = rdata;
    next_done = 1'b0;
    next_rd_en = 1'b0;
    next_wr_en = 1'b0;
    next_er_en = 1'b0;
    next_addr = addr;
    next_wbyte = wbyte;
    unique case (state)
      ENG_IDLE:
      begin
        // requests only arrive while idle, so nothing starts while busy
        if (req.start)
        begin
          next_done = 1'b1;
          next_addr = pointer;
          unique case (req.target)
            TGT_MODE:
            begin
              if (req.is_write)
                next_mode = req.wdata[17:10];
              next_rdata = {10'h000, mode};
            end
            TGT_POINTER:
            begin
              if (req.is_write)
                next_pointer = req.wdata[17:2];
              next_rdata = {2'h0, pointer};
            end
            TGT_DATA:
            begin
              next_rdata = {8'h00, byte_field, fail, 1'b0};
              if (req.is_write)
              begin
                next_byte_field = req.wdata[17:10];
                next_wbyte = req.wdata[17:10];
                if (write_mode == `WRMD_PROGRAM)
                begin
                  next_state = ENG_WRITE;
                  next_wr_en = 1'b1;
                  next_done = 1'b0;
                end
                else if (write_mode == `WRMD_ERASE &&
                         req.wdata[17:10] == `ERASE_KEY)
                begin
                  next_state = ENG_ERASE;
                  next_er_en = 1'b1;
                  next_done = 1'b0;
                end
              end
              else
              begin
                next_unread = 1'b0;
                // single mode skips the read that would fetch one too many
                if (read_mode == `RDMD_BLOCK ||
                    (read_mode == `RDMD_SINGLE && !unread))
                begin
                  next_state = ENG_READ;
                  next_rd_en = 1'b1;
                  next_done = 1'b0;
                end
              end
            end
            default:
              next_rdata = 18'h00000;
          endcase
        end
      end
      ENG_READ:
      begin
        if (flash_done)
        begin
          next_byte_field = flash_rdata;
          next_fail = flash_locked;
          next_unread = 1'b1;
          next_pointer = pointer + 16'h0001;
          next_state = ENG_IDLE;
          next_done = 1'b1;
        end
      end
      ENG_WRITE:
      begin
        if (flash_done)
        begin
          next_fail = flash_locked;
          next_pointer = pointer + 16'h0001;
          next_state = ENG_IDLE;
          next_done = 1'b1;
        end
      end
      ENG_ERASE:
      begin
        if (flash_done)
        begin
          next_fail = flash_locked;
          next_state = ENG_IDLE;
          next_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ENG_IDLE;
      mode <= `MODE_RESET;
      byte_field <= 8'(`BYTE_PORT_RESET >> `BYTE_FIELD_LO);
      fail <= 1'b0;
      pointer <= `POINTER_RESET;
      unread <= 1'b0;
      rdata <= 18'h00000;
      done <= 1'b0;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      er_en <= 1'b0;
      addr <= `POINTER_RESET;
      wbyte <= 8'h00;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      byte_field <= next_byte_field;
      fail <= next_fail;
      pointer <= next_pointer;
      unread <= next_unread;
      rdata <= next_rdata;
      done <= next_done;
      rd_en <= next_rd_en;
      wr_en <= next_wr_en;
      er_en <= next_er_en;
      addr <= next_addr;
      wbyte <= next_wbyte;
    end
  end

  assign req.done = done;
  assign req.rdata = rdata;
  assign flash_addr = addr;
  assign flash_wdata = wbyte;
  assign flash_rd_en = rd_en;
  assign flash_wr_en = wr_en;
  assign flash_erase_en = er_en;
  assign flash_scratch = mode[`SCRATCH_BIT];
endmodule // flash_engine

// File: tb/jtag_flash_data_access_asserts.sv
// concurrent checks on the flash test port and halt control
`timescale 1ns/1ps
module jtag_flash_data_access_chk
  import jtag_flash_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic flash_rd_en,
  input wire logic flash_wr_en,
  input wire logic flash_erase_en,
  input wire logic flash_done,
  input wire logic bkpt_hit,
  input wire logic core_halt,
  input wire logic core_step,
  input wire logic watchdog_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----
  // flash operation pending tracker
  // ----
  logic pend;
  logic next_pend;
  always_comb
  begin
    next_pend = pend;
    if (flash_rd_en || flash_wr_en || flash_erase_en)
      next_pend = 1'b1;
    else if (flash_done)
      next_pend = 1'b0;
  end
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      pend <= 1'b0;
    else
      pend <= next_pend;
  // ----
  // properties
  // ----
  sequence s_start;
    flash_rd_en || flash_wr_en || flash_erase_en;
  endsequence
  sequence s_step;
    core_step ##1 core_halt;
  endsequence
  property p_no_overlap; s_start |-> !pend; endproperty
  property p_one_op; $onehot0({flash_rd_en, flash_wr_en, flash_erase_en});
  endproperty
  property p_wr_pulse; flash_wr_en |=> !flash_wr_en; endproperty
  property p_rd_pulse; flash_rd_en |=> !flash_rd_en; endproperty
  property p_wdog_off; core_halt [*2] |-> !watchdog_enable; endproperty
  property p_wdog_on; !core_halt [*2] |-> watchdog_enable; endproperty
  property p_bkpt; $rose(bkpt_hit) |-> ##[1:4] core_halt; endproperty
  property p_step_src; core_step |-> $past(core_halt) && !core_halt;
  endproperty
  property p_step_back; core_step |-> s_step; endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("op overlap");
  a_one_op: assert property (p_one_op)
    else $error("two ops");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("wr long");
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("rd long");
  a_wdog_off: assert property (p_wdog_off)
    else $error("wdog on");
  a_wdog_on: assert property (p_wdog_on)
    else $error("wdog off");
  a_bkpt: assert property (p_bkpt)
    else $error("no halt");
  a_step_src: assert property (p_step_src)
    else $error("bad step");
  a_step_back: assert property (p_step_back)
    else $error("no rehalt");
endmodule // jtag_flash_data_access_chk

bind jtag_flash_data_access jtag_flash_data_access_chk u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .flash_rd_en(flash_rd_en),
  .flash_wr_en(flash_wr_en), .flash_erase_en(flash_erase_en),
  .flash_done(flash_done), .bkpt_hit(bkpt_hit), .core_halt(core_halt),
  .core_step(core_step), .watchdog_enable(watchdog_enable));

// File: tb/jtag_adapter.sv
// external debug adapter model driving the four-wire test port
`timescale 1ns/1ps
module jtag_adapter (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // test clock stands low between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic clock_bit(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #7.5 q = tdo;
    tck = 1'b1;
    #7.5 tck = 1'b0;
  endtask
  task automatic tap_reset();
    logic q;
    repeat (5) clock_bit(1'b1, ~tdi, q);
    clock_bit(1'b0, ~tdi, q);
  endtask
  // idle to shift, n bits lsb first, then update and back to idle
  task automatic shift(input logic ir, input logic [19:0] din, input int n,
                       output logic [19:0] dout);
    logic q;
    dout = 20'h00000;
    clock_bit(1'b1, ~tdi, q);
    if (ir)
      clock_bit(1'b1, ~tdi, q);
    clock_bit(1'b0, ~tdi, q);
    clock_bit(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++)
    begin
      clock_bit(i == n - 1, din[i], q);
      dout[i] = q;
    end
    clock_bit(1'b1, ~tdi, q);
    clock_bit(1'b0, ~tdi, q);
  endtask
endmodule // jtag_adapter

// File: tb/tb_jtag_flash_data_access.sv
// self-checking bench for the flash test port and halt control
`timescale 1ns/1ps
`include "jtag_flash_cfg.svh"
module tb_jtag_flash_data_access;
  import jtag_flash_pkg::*;
  logic sys_clk, reset_n, tck, tms, tdi, tdo, tdo_oe, lock, lk1, lk2, scr;
  logic [15:0] flash_addr, op_addr, p;
  logic [7:0] flash_wdata, flash_rdata, op_wdata, b;
  logic flash_rd_en, flash_wr_en, flash_erase_en, flash_done, flash_locked;
  logic bkpt_hit, core_halt, core_step, watchdog_enable;
  logic [17:0] r;
  logic [19:0] q;
  int err_count, tests_run, seed, cnt, dly, n_wr, n_rd, n_step, s;

  jtag_flash_data_access u_dut (.sys_clk, .reset_n, .tck, .tms, .tdi, .tdo,
    .tdo_oe, .flash_addr, .flash_wdata, .flash_rd_en, .flash_wr_en,
    .flash_erase_en, .flash_scratch(scr), .flash_rdata, .flash_done,
    .flash_locked, .bkpt_hit, .core_halt, .core_step, .watchdog_enable);
  jtag_adapter u_adp (.tck, .tms, .tdi, .tdo);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ----
  // flash array model, answers after dly cycles
  // ----
  function automatic logic [7:0] fbyte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  always @(posedge sys_clk)
  begin
    flash_done <= (cnt == 1);
    if (cnt != 0)
      cnt <= cnt - 1;
    // released read bus no longer shows the old byte
    if (flash_done)
      flash_rdata <= ~flash_rdata;
    if (flash_rd_en | flash_wr_en | flash_erase_en)
    begin
      cnt <= dly;
      op_addr <= flash_addr;
      op_wdata <= flash_wdata;
      flash_rdata <= fbyte(flash_addr);
      flash_locked <= lock;
      n_wr <= n_wr + 32'(flash_wr_en);
      n_rd <= n_rd + 32'(flash_rd_en);
    end
    if (core_step === 1'b1)
      n_step <= n_step + 1;
  end
  // ----
  // tasks
  // ----
  task chk(input string n, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task note(input string t);
    $display("test %s done", t);
  endtask
  task end_sim();
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded busy poll; read data comes back once busy is low
  task automatic poll();
    for (int k = 0; k < 100; k++)
    begin
      u_adp.shift(1'b0, 20'h00000, 20, q);
      if (q[0] === 1'b0)
      begin
        r = q[18:1];
        @(negedge sys_clk);
        return;
      end
    end
    err_count++;
    end_sim();
  endtask
  task automatic op(input logic [3:0] ir, input logic wr,
                    input logic [17:0] d);
    u_adp.shift(1'b1, {16'h0000, ir}, 4, q);
    u_adp.shift(1'b0, {1'b1, wr, d}, 20, q);
    poll();
  endtask
  initial
  begin
    #4000000;
    err_count++;
    end_sim();
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    seed = 16385;
    reset_n = 1'b0;
    bkpt_hit = 1'b0;
    flash_done = 1'b0;
    flash_rdata = 8'h00;
    flash_locked = 1'b0;
    lock = 1'b0;
    cnt = 0;
    dly = 3;
    n_wr = 0;
    n_rd = 0;
    n_step = 0;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    u_adp.tap_reset();
    op(`IR_MODE_SEL, 1'b1, {8'h11, 10'h000});
    p = 16'($random(seed));
    op(`IR_POINTER_SEL, 1'b1, {p, 2'b00});
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($random(seed));
      lock = 1'($random(seed));
      dly = 2 + ($random(seed) & 7);
      op(`IR_DATA_SEL, 1'b1, {b, 10'h000});
      chk("wr_addr", {2'b00, op_addr}, {2'b00, p});
      chk("wr_byte", {10'h000, op_wdata}, {10'h000, b});
      lk1 = lock;
      lock = 1'($random(seed));
      op(`IR_DATA_SEL, 1'b0, 18'h00000);
      chk("rd_old", {8'h00, r[9:0]}, {8'h00, b, lk1, 1'b0});
      chk("rd_addr", {2'b00, op_addr}, {2'b00, p + 16'h0001});
      lk2 = lock;
      lock = 1'($random(seed));
      op(`IR_DATA_SEL, 1'b0, 18'h00000);
      chk("rd_new", {8'h00, r[9:0]},
          {8'h00, fbyte(p + 16'h0001), lk2, 1'b0});
      p = p + 16'h0003;
    end
    op(`IR_POINTER_SEL, 1'b0, 18'h00000);
    chk("pointer", {2'b00, r[15:0]}, {2'b00, p});
    note("data");
    // second write lands while the first still waits on the array
    dly = 60;
    s = n_wr;
    u_adp.shift(1'b1, {16'h0000, `IR_DATA_SEL}, 4, q);
    u_adp.shift(1'b0, {2'b11, 8'h3C, 10'h000}, 20, q);
    u_adp.shift(1'b0, {2'b11, 8'hC3, 10'h000}, 20, q);
    u_adp.shift(1'b0, 20'h00000, 1, q);
    chk("busy", {17'h00000, q[0]}, 18'h00001);
    poll();
    chk("refused", 18'(n_wr - s), 18'h00001);
    chk("kept", {10'h000, op_wdata}, 18'h0003C);
    note("busy");
    // erase, scratch select and single-read mode
    p = p + 16'h0001;
    chk("oe_idle", {17'h00000, tdo_oe}, 18'h00000);
    op(`IR_MODE_SEL, 1'b1, {8'hA2, 10'h000});
    chk("scratch", {17'h00000, scr}, 18'h00001);
    op(`IR_DATA_SEL, 1'b1, {`ERASE_KEY, 10'h000});
    chk("erase_addr", {2'b00, op_addr}, {2'b00, p});
    s = n_rd;
    op(`IR_DATA_SEL, 1'b0, 18'h00000);
    op(`IR_DATA_SEL, 1'b0, 18'h00000);
    chk("single", 18'(n_rd - s), 18'h00001);
    op(`IR_POINTER_SEL, 1'b0, 18'h00000);
    chk("erase_ptr", {2'b00, r[15:0]}, {2'b00, p + 16'h0001});
    note("modes");
    @(posedge sys_clk);
    bkpt_hit <= 1'b1;
    @(posedge sys_clk);
    bkpt_hit <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk("halt", {17'h00000, core_halt}, 18'h00001);
    chk("wdog_off", {17'h00000, watchdog_enable}, 18'h00000);
    s = n_step;
    op(`IR_DEBUG_SEL, 1'b1, 18'h10000);
    chk("step", 18'(n_step - s), 18'h00001);
    chk("wdog_step", {17'h00000, watchdog_enable}, 18'h00000);
    op(`IR_DEBUG_SEL, 1'b0, 18'h00000);
    chk("dbg_rd", {17'h00000, r[0]}, 18'h00001);
    op(`IR_DEBUG_SEL, 1'b1, 18'h08000);
    chk("resume", {17'h00000, core_halt}, 18'h00000);
    chk("wdog_on", {17'h00000, watchdog_enable}, 18'h00001);
    note("debug");
    end_sim();
  end
endmodule // tb_jtag_flash_data_access
